// *** design/dcsp_consts.svh ***
/*
  constants of the three-wire configuration serial port: field positions,
  reset values and address limits.
  assumes it is included by its bare name, once per compilation unit.
*/
// Behaviour
// - every cycle starts with an eight-bit instruction on the first rising edges
// - chip select high then low restarts the instruction phase
// - all later clock edges of the cycle move data bytes
// - a written byte lands in its register right after its last bit
// - instruction top bit one means read, zero means write
// - lower seven instruction bits give the start register address
// - the port steps the address itself for each further byte
// - single and multibyte transfers, both bit orders supported
// - bits are taken on rising clock, read bits driven on falling clock
// - data pin released while chip select is high
// - msb-first steps down toward 0x00, lsb-first up toward 0x7f
// - bit order resets to msb first, applies to instruction and data
`ifndef DCSP_CONSTS_SVH
`define DCSP_CONSTS_SVH

// ==========================================================
// instruction and control fields
`define DCSP_INSTR_RW_BIT   7
`define DCSP_CFG_ADDR       7'h00
`define DCSP_CFG_SDIO_BIT   7
`define DCSP_CFG_LSB_BIT    6
`define DCSP_ADDR_LOW       7'h00
`define DCSP_ADDR_HIGH      7'h7f
`define DCSP_LAST_BIT       3'h7
`define DCSP_REG_RESET      8'h00
`define DCSP_NUM_REGS       128

`endif

// *** design/dcsp_pkg.sv ***
/*
  types of the configuration serial port.
  assumes dcsp_consts.svh is not needed here; widths are fixed by the byte format.
*/
package dcsp_pkg;

  // ==========================================================
  // serial phase
  typedef enum logic {
    ST_INSTR,
    ST_DATA
  } dcsp_state_t;

  // ==========================================================
  // register write notice towards the core
  typedef struct packed {
    logic       stb;
    logic [6:0] addr;
    logic [7:0] data;
  } dcsp_wr_t;

endpackage

// *** design/dcsp_serial_port.sv ***
/*
  three-wire configuration serial port with its 128-byte register file.
  assumes serial clock well below ref_clk/4 so every pin edge is seen after sync;
  chip select idles high (pull-up outside), ref_clk 100 MHz.
*/
`timescale 1ns/1ns
`include "dcsp_consts.svh"
module dcsp_serial_port #(
  parameter int NUM_REGS = `DCSP_NUM_REGS
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdioIn,
  output logic                   sdioOut,
  output logic                   sdioOe_n,
  output dcsp_pkg::dcsp_wr_t     regWr,
  output logic                   cfgLsbFirst,
  output logic                   cfgSdioRead
);

  // ==========================================================
  // pin synchronisation and edge finding
  logic [2:0]            syncOut;
  logic                  sclkPrev_ff;
  dcsp_pkg::dcsp_state_t state_ff;
  dcsp_pkg::dcsp_state_t nxt_state;
  logic [2:0]            bitCnt_ff;
  logic [7:0]            shift_ff;
  logic                  rw_ff;
  logic [6:0]            addr_ff;
  logic [7:0]            tx_ff;
  logic [7:0]            mem_ff [NUM_REGS];
  logic                  sdioOut_ff;
  logic                  sdioOe_n_ff;
  dcsp_pkg::dcsp_wr_t    regWr_ff;

  dcsp_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({sdioIn, cs_n, sclk}),
    .dout    (syncOut)
  );

  // ==========================================================
  // address stepping, saturates at either end
  function automatic logic [6:0] stepAddr(input logic [6:0] a, input logic up);
    if (up) begin
      stepAddr = (a == `DCSP_ADDR_HIGH) ? a : 7'(a + 7'h01);
    end else begin
      stepAddr = (a == `DCSP_ADDR_LOW) ? a : 7'(a - 7'h01);
    end
  endfunction

  // ==========================================================
  // decode of edges, byte assembly and read bit select
  wire       sclkS    = syncOut[0];
  wire       csHigh   = syncOut[1];
  wire       sdioS    = syncOut[2];
  wire       lsbFirst = mem_ff[`DCSP_CFG_ADDR][`DCSP_CFG_LSB_BIT];
  wire       sdioRead = mem_ff[`DCSP_CFG_ADDR][`DCSP_CFG_SDIO_BIT];
  wire       sclkRise = sclkS & ~sclkPrev_ff;
  wire       sclkFall = ~sclkS & sclkPrev_ff;
  wire       takeBit  = sclkRise & ~csHigh;
  wire       byteDone = takeBit & (bitCnt_ff == `DCSP_LAST_BIT);
  wire       instrEnd = byteDone & (state_ff == dcsp_pkg::ST_INSTR);
  wire       dataEnd  = byteDone & (state_ff == dcsp_pkg::ST_DATA);
  wire [7:0] nxtByte  = lsbFirst ? {sdioS, shift_ff[7:1]} : {shift_ff[6:0], sdioS};
  wire [6:0] addrNext = stepAddr(addr_ff, lsbFirst);
  wire [2:0] txIdx    = lsbFirst ? bitCnt_ff : 3'(`DCSP_LAST_BIT - bitCnt_ff);
  wire       driveBit = sclkFall & ~csHigh & (state_ff == dcsp_pkg::ST_DATA) & rw_ff & sdioRead;

  // ==========================================================
  // phase sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dcsp_pkg::ST_INSTR: begin
        if (instrEnd) begin
          nxt_state = dcsp_pkg::ST_DATA;
        end
      end
      dcsp_pkg::ST_DATA: begin
        nxt_state = dcsp_pkg::ST_DATA;
      end
      default: begin
        nxt_state = dcsp_pkg::ST_INSTR;
      end
    endcase
    if (csHigh) begin
      nxt_state = dcsp_pkg::ST_INSTR;
    end
  end

  // state, edge history and bit count; deselect also drops a partial byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= dcsp_pkg::ST_INSTR;
      sclkPrev_ff <= 1'b0;
      bitCnt_ff   <= 3'h0;
    end else begin
      state_ff    <= nxt_state;
      sclkPrev_ff <= sclkS;
      if (csHigh) begin
        bitCnt_ff <= 3'h0;
      end else if (sclkRise) begin
        bitCnt_ff <= 3'(bitCnt_ff + 3'h1);
      end
    end
  end

  // ==========================================================
  // shift register and instruction fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= 8'h00;
      rw_ff    <= 1'b0;
      addr_ff  <= 7'h00;
    end else begin
      if (takeBit) begin
        shift_ff <= nxtByte;
      end
      if (instrEnd) begin
        rw_ff   <= nxtByte[`DCSP_INSTR_RW_BIT];
        addr_ff <= nxtByte[6:0];
      end else if (dataEnd) begin
        addr_ff <= addrNext;
      end
    end
  end

  // ==========================================================
  // register file; only whole bytes are ever written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_ff[i] <= `DCSP_REG_RESET;
      end
    end else if (dataEnd & ~rw_ff) begin
      mem_ff[addr_ff] <= nxtByte;
    end
  end

  // write notice and read byte preload at each byte boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regWr_ff <= '0;
      tx_ff    <= 8'h00;
    end else begin
      regWr_ff.stb  <= dataEnd & ~rw_ff;
      regWr_ff.addr <= addr_ff;
      regWr_ff.data <= nxtByte;
      if (instrEnd) begin
        tx_ff <= mem_ff[nxtByte[6:0]];
      end else if (dataEnd) begin
        tx_ff <= mem_ff[addrNext];
      end
    end
  end

  // ==========================================================
  // data pin drive; enable is low while driving
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdioOut_ff  <= 1'b0;
      sdioOe_n_ff <= 1'b1;
    end else if (csHigh) begin
      sdioOut_ff  <= 1'b0;
      sdioOe_n_ff <= 1'b1;
    end else if (driveBit) begin
      sdioOut_ff  <= tx_ff[txIdx];
      sdioOe_n_ff <= 1'b0;
    end
  end

  // outputs straight from flops
  assign sdioOut     = sdioOut_ff;
  assign sdioOe_n    = sdioOe_n_ff;
  assign regWr       = regWr_ff;
  assign cfgLsbFirst = lsbFirst;
  assign cfgSdioRead = sdioRead;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_instr_end;
    instrEnd |=> state_ff == dcsp_pkg::ST_DATA && bitCnt_ff == 3'h0;
  endproperty
  a_instr_end: assert property (p_instr_end) else $error("no data phase after instr");

  property p_restart;
    csHigh |=> state_ff == dcsp_pkg::ST_INSTR && bitCnt_ff == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("deselect did not restart");

  property p_data_hold;
    state_ff == dcsp_pkg::ST_DATA && !csHigh |=> state_ff == dcsp_pkg::ST_DATA;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("left data phase early");

  property p_write_now;
    dataEnd && !rw_ff |=> regWr.stb && mem_ff[regWr.addr] == regWr.data
      && regWr.addr == $past(addr_ff);
  endproperty
  a_write_now: assert property (p_write_now) else $error("byte not written at once");

  property p_dir_addr;
    instrEnd |=> rw_ff == $past(nxtByte[7]) && addr_ff == $past(nxtByte[6:0]);
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("instruction fields wrong");

  property p_step_up;
    dataEnd && lsbFirst && addr_ff != `DCSP_ADDR_HIGH |=> addr_ff == 7'($past(addr_ff) + 7'h01);
  endproperty
  a_step_up: assert property (p_step_up) else $error("lsb-first step wrong");

  property p_step_down;
    dataEnd && !lsbFirst && addr_ff != `DCSP_ADDR_LOW |=> addr_ff == 7'($past(addr_ff) - 7'h01);
  endproperty
  a_step_down: assert property (p_step_down) else $error("msb-first step wrong");

  property p_hiz;
    csHigh |=> sdioOe_n ##1 sdioOe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while deselected");

  property p_fall_only;
    $fell(sdioOe_n) || (!sdioOe_n && $changed(sdioOut)) |-> $past(sclkFall);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("read bit off falling edge");

  property p_no_partial;
    csHigh |=> !regWr.stb [*2];
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("write after deselect");

endmodule

// *** design/dcsp_sync.sv ***
/*
  two-flop level synchroniser for the serial port pins.
  assumes inputs are asynchronous to ref_clk and change slowly next to it.
*/
`timescale 1ns/1ns
module dcsp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_ff;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      dout      <= '0;
    end else begin
      stage1_ff <= din;
      dout      <= stage1_ff;
    end
  end

endmodule

// *** testbench/dcsp_host_model.sv ***
/*
  host model for the three-wire port: drives clock, select and data.
  assumes the bench calls its tasks; pins change on falling ref_clk.
*/
`timescale 1ns/1ns
module dcsp_host_model (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      hostOe,
  output logic      hostBit,
  input  wire logic sdioWire
);
  // ==========================================================
  // idle pins: select high, data released
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
  end

  task automatic waitn(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // select edges, sclk parked while cs_n moves
  task automatic sel(input logic on);
    cs_n = ~on;
    waitn(4);
    sclk = 1'b0;
    hostOe = 1'b0;
    waitn(4);
  endtask

  // drive in low half, sample just before rise
  task automatic shift_bit(input logic tx, input logic drive, output logic rx);
    sclk = 1'b0;
    hostOe = drive;
    hostBit = tx;
    waitn(8);
    rx = sdioWire;
    sclk = 1'b1;
    waitn(8);
  endtask

  // eight bits in the chosen order
  task automatic shift_byte(input logic [7:0] tx, input bit lsb, input logic drive,
                            output logic [7:0] rx);
    logic b;
    for (int i = 0; i < 8; i++) begin
      shift_bit(tx[lsb ? i : 7 - i], drive, b);
      rx[lsb ? i : 7 - i] = b;
    end
  endtask
endmodule

// *** testbench/tb.sv ***
/*
  self-checking bench of the configuration serial port against a model.
  assumes the host model paces all pin activity from ref_clk.
*/
`timescale 1ns/1ns
module tb;
  logic               ref_clk, rst_n, sdioOut, sdioOe_n, cfgLsbFirst, cfgSdioRead;
  logic               sclk, cs_n, hostOe, hostBit, togl, sdioWire;
  logic [7:0]         rx;
  dcsp_pkg::dcsp_wr_t regWr;
  int                 fails, cmp_count, cyc, oeBase;
  int                 oeCnt = 0;
  int                 mem [128];
  int                 expQ [$];
  bit                 lsbM;

  // released line shows a changing pattern, never the last value
  assign sdioWire = !sdioOe_n ? sdioOut : (hostOe ? hostBit : togl);
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  dcsp_serial_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .sdioIn(sdioWire), .sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .regWr(regWr),
    .cfgLsbFirst(cfgLsbFirst), .cfgSdioRead(cfgSdioRead));
  dcsp_host_model u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .hostOe(hostOe),
    .hostBit(hostBit), .sdioWire(sdioWire));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // write notices against the model, driven-pin count, plus a hang limit
  always @(posedge ref_clk) begin
    togl <= ~togl;
    cyc <= cyc + 1;
    if (sdioOe_n === 1'b0) oeCnt <= oeCnt + 1;
    if (rst_n && regWr.stb === 1'b1) begin
      if (expQ.size() == 0) check("stray write", 16'h0000, {1'b1, regWr.addr, regWr.data});
      else check("write", expQ.pop_front(), {1'b0, regWr.addr, regWr.data});
    end
    // last, so that nothing runs after the run has ended
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // one whole cycle; dat below zero means random data
  task automatic xfer(input bit rd, input int addr, input int n, input int dat);
    int a;
    logic [7:0] tx;
    a = addr;
    u_host.sel(1'b1);
    u_host.shift_byte({rd, 7'(addr)}, lsbM, 1'b1, rx);
    for (int k = 0; k < n; k++) begin
      tx = (dat < 0) ? 8'($urandom) : 8'(dat);
      if (!rd) begin
        expQ.push_back(a * 256 + tx);
        mem[a] = tx;
      end
      u_host.shift_byte(tx, lsbM, !rd, rx);
      if (rd) check("read data", 16'(mem[a]), {8'h00, rx});
      if (!rd && a == 0) lsbM = tx[6];
      a = lsbM ? (a < 127 ? a + 1 : 127) : (a > 0 ? a - 1 : 0);
    end
    u_host.sel(1'b0);
    check("pin released", 16'h0001, {15'h0000, sdioOe_n});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    togl = 1'b0;
    cyc = 0;
    fails = 0;
    cmp_count = 0;
    lsbM = 1'b0;
    foreach (mem[i]) mem[i] = 0;
    void'($urandom(82));
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("reset order", 16'h0000, {15'h0000, cfgLsbFirst});
    check("reset readback", 16'h0000, {15'h0000, cfgSdioRead});
    // readback still off: a read must leave the pin released throughout
    oeBase = oeCnt;
    u_host.sel(1'b1);
    u_host.shift_byte(8'h85, 1'b0, 1'b1, rx);
    u_host.shift_byte(8'h00, 1'b0, 1'b0, rx);
    u_host.sel(1'b0);
    check("read refused", 16'(oeBase), 16'(oeCnt));
    $display("test reset done");
    xfer(0, 0, 1, 'h80);
    check("readback on", 16'h0001, {15'h0000, cfgSdioRead});
    xfer(0, 'h11, 3, -1);
    xfer(1, 'h11, 3, -1);
    $display("test msb multibyte done");
    xfer(0, 'h20, 1, -1);
    u_host.sel(1'b1);
    u_host.shift_byte(8'h20, 1'b0, 1'b1, rx);
    for (int i = 0; i < 5; i++) u_host.shift_bit(1'b1, 1'b1, rx[0]);
    u_host.sel(1'b0);
    xfer(1, 'h20, 1, -1);
    $display("test abort done");
    xfer(0, 0, 1, 'hc0);
    check("lsb mode", 16'h0001, {15'h0000, cfgLsbFirst});
    xfer(0, 'h7e, 3, -1);
    xfer(1, 'h7d, 4, -1);
    xfer(0, 0, 1, 'h80);
    check("msb mode", 16'h0000, {15'h0000, cfgLsbFirst});
    xfer(1, 'h12, 2, -1);
    $display("test lsb multibyte done");
    test_done();
  end
endmodule
